// >>> hdl/mfrp_pkg.sv
// constants of the multi-line flash read path
package mfrp_pkg;

    // ========================
    // protocols and line widths
    localparam logic [1:0] MFRP_PROTO_EXT = 2'h0;
    localparam logic [1:0] MFRP_PROTO_DUAL = 2'h1;
    localparam logic [1:0] MFRP_PROTO_QUAD = 2'h2;
    localparam logic [2:0] MFRP_W1 = 3'h1;
    localparam logic [2:0] MFRP_W2 = 3'h2;
    localparam logic [2:0] MFRP_W4 = 3'h4;

    // ========================
    // read opcodes
    localparam logic [7:0] MFRP_OP_READ = 8'h03;
    localparam logic [7:0] MFRP_OP_FAST = 8'h0b;
    localparam logic [7:0] MFRP_OP_DOUT = 8'h3b;
    localparam logic [7:0] MFRP_OP_DIO = 8'hbb;
    localparam logic [7:0] MFRP_OP_QOUT = 8'h6b;
    localparam logic [7:0] MFRP_OP_QIO = 8'heb;

    // ========================
    // frame lengths in bits and dummy clocks (dummy plus mode clocks)
    localparam logic [4:0] MFRP_CMD_BITS = 5'h08;
    localparam logic [4:0] MFRP_ADDR_BITS = 5'h18;
    localparam logic [3:0] MFRP_BYTE_BITS = 4'h8;
    localparam logic [3:0] MFRP_DUMMY_READ = 4'h0;
    localparam logic [3:0] MFRP_DUMMY_FAST = 4'h8;
    localparam logic [3:0] MFRP_DUMMY_FAST_QUAD = 4'ha;
    localparam logic [3:0] MFRP_DUMMY_DIO_DUAL = 4'h9;
    localparam logic [3:0] MFRP_DUMMY_QIO_EXT = 4'ha;
    localparam logic [3:0] MFRP_DUMMY_QIO_QUAD = 4'hb;

    // ========================
    // reset values, data-phase drive enables and empty-fifo fill byte
    localparam logic [23:0] MFRP_ADDR_RESET = 24'h000000;
    localparam logic [3:0] MFRP_OE_N_IDLE = 4'hf;
    localparam logic [3:0] MFRP_OE_N_W1 = 4'hd;
    localparam logic [3:0] MFRP_OE_N_W2 = 4'hc;
    localparam logic [3:0] MFRP_OE_N_W4 = 4'h0;
    localparam logic [7:0] MFRP_FILL_BYTE = 8'hff;

    // ========================
    // discovery table
    localparam int MFRP_TBL_AW = 11;
    localparam logic [10:0] MFRP_TBL_DENS0 = 11'h034;
    localparam logic [10:0] MFRP_TBL_DENS1 = 11'h035;
    localparam logic [10:0] MFRP_TBL_DENS2 = 11'h036;
    localparam logic [10:0] MFRP_TBL_DENS3 = 11'h037;
    localparam logic [10:0] MFRP_TBL_144 = 11'h038;
    localparam logic [10:0] MFRP_TBL_114 = 11'h03a;
    localparam logic [10:0] MFRP_TBL_112 = 11'h03c;
    localparam logic [10:0] MFRP_TBL_122 = 11'h03e;
    localparam logic [10:0] MFRP_TBL_CAPS = 11'h040;
    localparam logic [10:0] MFRP_TBL_222 = 11'h046;
    localparam logic [10:0] MFRP_TBL_444 = 11'h04a;
    localparam logic [10:0] MFRP_TBL_ERASE1 = 11'h04c;
    localparam logic [10:0] MFRP_TBL_ERASE2 = 11'h04e;
    localparam logic [10:0] MFRP_TBL_ERASE3 = 11'h050;
    localparam logic [10:0] MFRP_TBL_ERASE4 = 11'h052;
    localparam logic [7:0] MFRP_DENS_LOW = 8'hff;
    localparam logic [7:0] MFRP_DENS_TOP = 8'h07;
    localparam logic [4:0] MFRP_D144 = 5'h09;
    localparam logic [4:0] MFRP_D114 = 5'h07;
    localparam logic [4:0] MFRP_D112 = 5'h08;
    localparam logic [4:0] MFRP_D122 = 5'h07;
    localparam logic [4:0] MFRP_D222 = 5'h08;
    localparam logic [4:0] MFRP_D444 = 5'h0a;
    localparam logic [2:0] MFRP_MODE_ONE = 3'h1;
    localparam logic [2:0] MFRP_MODE_NONE = 3'h0;
    localparam logic [2:0] MFRP_RSVD3 = 3'h7;
    localparam logic [7:0] MFRP_ERASE1_EXP = 8'h0c;
    localparam logic [7:0] MFRP_ERASE1_OP = 8'h20;
    localparam logic [7:0] MFRP_ERASE2_EXP = 8'h10;
    localparam logic [7:0] MFRP_ERASE2_OP = 8'hd8;
    localparam logic [7:0] MFRP_ERASE_NONE = 8'h00;
    localparam logic [7:0] MFRP_TBL_BLANK = 8'hff;

    // ========================
    // buffering
    localparam int MFRP_FIFO_DEPTH = 32;

endpackage

// >>> hdl/mfrp_read_path.sv
// flash read path: serial front end, prefetch fifo and discovery table
// Behaviour
// - decode 24-bit byte address for every read
// - command then three address bytes precede data
// - capture address bits on serial clock rise
// - advance address by one per data byte
// - chip select high stops drive, abandons command
// - fast reads insert dummy clocks, plain none
// - accept opcode set allowed by each protocol
// - line count per phase, opcode and protocol
// - table 144 entry: dummy 9, mode 1, EB
// - table 114 entry: dummy 7, mode 1, 6B
// - table 112 entry: dummy 8, mode 0, 3B
// - table 122 entry: dummy 7, mode 1, BB
// - table 222 entry: dummy 8, mode 1, BB
// - table 444 entry: dummy 10, mode 1, EB
// - byte 40h caps bits, reserved bytes ones
// - density bytes FF FF FF 07
// - two erase types, types three four zero
// - table pointer wraps at 2048 bytes
`timescale 1ns/100ps
`default_nettype none

// ========================
// prefetch fifo
module mfrp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign o_in_ready = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rd_ptr];
    assign push = i_in_valid && o_in_ready && !i_flush;
    assign pop = o_out_valid && i_out_ready && !i_flush;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (i_flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // mfrp_fifo

// ========================
// top
module mfrp_read_path
    import mfrp_pkg::*;
#(
    parameter int FIFO_DEPTH = MFRP_FIFO_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic [1:0] i_proto,
    input wire logic [3:0] i_io,
    output logic [3:0] o_io,
    output logic [3:0] o_io_oe_n,
    output logic [23:0] o_mem_addr,
    output logic o_mem_rd,
    input wire logic [7:0] i_mem_data,
    input wire logic i_mem_valid,
    output logic o_mem_ready,
    input wire logic i_tbl_load,
    input wire logic [10:0] i_tbl_addr,
    input wire logic i_tbl_next,
    output logic [7:0] o_tbl_data
);
    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} mfrp_state_t;

    // ========================
    // functions
    function automatic logic [2:0] proto_w(input logic [1:0] p);
        return (p == MFRP_PROTO_EXT) ? MFRP_W1 : (p == MFRP_PROTO_DUAL) ? MFRP_W2 : MFRP_W4;
    endfunction

    function automatic logic op_ok(input logic [7:0] op, input logic [1:0] p);
        case (p)
            MFRP_PROTO_EXT: return op inside {MFRP_OP_READ, MFRP_OP_FAST, MFRP_OP_DOUT,
                MFRP_OP_DIO, MFRP_OP_QOUT, MFRP_OP_QIO};
            MFRP_PROTO_DUAL: return op inside {MFRP_OP_FAST, MFRP_OP_DOUT, MFRP_OP_DIO};
            MFRP_PROTO_QUAD: return op inside {MFRP_OP_FAST, MFRP_OP_QOUT, MFRP_OP_QIO};
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [2:0] addr_w(input logic [7:0] op, input logic [1:0] p);
        if (p != MFRP_PROTO_EXT) begin
            return proto_w(p);
        end
        case (op)
            MFRP_OP_DIO: return MFRP_W2;
            MFRP_OP_QIO: return MFRP_W4;
            default: return MFRP_W1;
        endcase
    endfunction

    function automatic logic [2:0] data_w(input logic [7:0] op, input logic [1:0] p);
        if (p != MFRP_PROTO_EXT) begin
            return proto_w(p);
        end
        case (op)
            MFRP_OP_DOUT, MFRP_OP_DIO: return MFRP_W2;
            MFRP_OP_QOUT, MFRP_OP_QIO: return MFRP_W4;
            default: return MFRP_W1;
        endcase
    endfunction

    function automatic logic [3:0] dummy_of(input logic [7:0] op, input logic [1:0] p);
        case (op)
            MFRP_OP_READ: return MFRP_DUMMY_READ;
            MFRP_OP_FAST: return (p == MFRP_PROTO_QUAD) ? MFRP_DUMMY_FAST_QUAD : MFRP_DUMMY_FAST;
            MFRP_OP_DIO: return (p == MFRP_PROTO_DUAL) ? MFRP_DUMMY_DIO_DUAL : MFRP_DUMMY_FAST;
            MFRP_OP_QIO: return (p == MFRP_PROTO_QUAD) ? MFRP_DUMMY_QIO_QUAD : MFRP_DUMMY_QIO_EXT;
            default: return MFRP_DUMMY_FAST;
        endcase
    endfunction

    function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [3:0] d, input logic [2:0] w);
        case (w)
            MFRP_W1: return {v[22:0], d[0]};
            MFRP_W2: return {v[21:0], d[1:0]};
            default: return {v[19:0], d};
        endcase
    endfunction

    function automatic logic [3:0] top_bits(input logic [7:0] b, input logic [2:0] w);
        case (w)
            MFRP_W1: return {2'h0, b[7], 1'b0};
            MFRP_W2: return {2'h0, b[7:6]};
            default: return b[7:4];
        endcase
    endfunction

    function automatic logic [7:0] tbl_byte(input logic [10:0] a);
        case (a)
            MFRP_TBL_DENS0, MFRP_TBL_DENS1, MFRP_TBL_DENS2: return MFRP_DENS_LOW;
            MFRP_TBL_DENS3: return MFRP_DENS_TOP;
            MFRP_TBL_144: return {MFRP_MODE_ONE, MFRP_D144};
            MFRP_TBL_144 + 11'h001: return MFRP_OP_QIO;
            MFRP_TBL_114: return {MFRP_MODE_ONE, MFRP_D114};
            MFRP_TBL_114 + 11'h001: return MFRP_OP_QOUT;
            MFRP_TBL_112: return {MFRP_MODE_NONE, MFRP_D112};
            MFRP_TBL_112 + 11'h001: return MFRP_OP_DOUT;
            MFRP_TBL_122: return {MFRP_MODE_ONE, MFRP_D122};
            MFRP_TBL_122 + 11'h001: return MFRP_OP_DIO;
            MFRP_TBL_CAPS: return {MFRP_RSVD3, 1'b1, MFRP_RSVD3, 1'b1};
            MFRP_TBL_222: return {MFRP_MODE_ONE, MFRP_D222};
            MFRP_TBL_222 + 11'h001: return MFRP_OP_DIO;
            MFRP_TBL_444: return {MFRP_MODE_ONE, MFRP_D444};
            MFRP_TBL_444 + 11'h001: return MFRP_OP_QIO;
            MFRP_TBL_ERASE1: return MFRP_ERASE1_EXP;
            MFRP_TBL_ERASE1 + 11'h001: return MFRP_ERASE1_OP;
            MFRP_TBL_ERASE2: return MFRP_ERASE2_EXP;
            MFRP_TBL_ERASE2 + 11'h001: return MFRP_ERASE2_OP;
            MFRP_TBL_ERASE3, MFRP_TBL_ERASE3 + 11'h001,
            MFRP_TBL_ERASE4, MFRP_TBL_ERASE4 + 11'h001: return MFRP_ERASE_NONE;
            default: return MFRP_TBL_BLANK;
        endcase
    endfunction

    // ========================
    // reset release and pin synchronisers
    logic rst_s1;
    logic rst_n;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic cs_s1;
    logic cs_s2;
    logic [3:0] io_s1;
    logic [3:0] io_s2;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_d <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            io_s1 <= 4'h0;
            io_s2 <= 4'h0;
        end else begin
            sclk_s1 <= i_sclk;
            sclk_s2 <= sclk_s1;
            sclk_d <= sclk_s2;
            cs_s1 <= i_cs_n;
            cs_s2 <= cs_s1;
            io_s1 <= i_io;
            io_s2 <= io_s1;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    assign sclk_rise = sclk_s2 && !sclk_d;
    assign sclk_fall = !sclk_s2 && sclk_d;

    // ========================
    // command, address and dummy sequencing
    mfrp_state_t state;
    logic [1:0] proto;
    logic [7:0] op;
    logic [23:0] shreg;
    logic [4:0] bit_cnt;
    logic [3:0] dummy_left;
    logic [2:0] cur_w;
    logic [23:0] next_shreg;
    logic [4:0] next_bits;

    always_comb begin
        cur_w = (state == ST_CMD) ? proto_w(proto) : addr_w(op, proto);
        next_shreg = shift_in(shreg, io_s2, cur_w);
        next_bits = bit_cnt + {2'h0, cur_w};
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            proto <= MFRP_PROTO_EXT;
            op <= 8'h00;
            shreg <= MFRP_ADDR_RESET;
            bit_cnt <= 5'h00;
            dummy_left <= 4'h0;
        end else if (cs_s2) begin
            state <= ST_IDLE;
            bit_cnt <= 5'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    state <= ST_CMD;
                    proto <= i_proto;
                end
                ST_CMD: begin
                    if (sclk_rise) begin
                        shreg <= next_shreg;
                        bit_cnt <= next_bits;
                        if (next_bits == MFRP_CMD_BITS) begin
                            op <= next_shreg[7:0];
                            bit_cnt <= 5'h00;
                            state <= op_ok(next_shreg[7:0], proto) ? ST_ADDR : ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    if (sclk_rise) begin
                        shreg <= next_shreg;
                        bit_cnt <= next_bits;
                        if (next_bits == MFRP_ADDR_BITS) begin
                            dummy_left <= dummy_of(op, proto);
                            state <= (dummy_of(op, proto) == 4'h0) ? ST_DATA : ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (sclk_rise) begin
                        dummy_left <= dummy_left - 4'h1;
                        if (dummy_left == 4'h1) begin
                            state <= ST_DATA;
                        end
                    end
                end
                ST_DATA, ST_IGNORE: begin
                    state <= state;
                end
                default: begin
                    state <= ST_IGNORE;
                end
            endcase
        end
    end

    // ========================
    // prefetch from the array
    logic fetching;
    logic pending;
    logic live;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;
    logic addr_done;

    assign addr_done = !cs_s2 && state == ST_ADDR && sclk_rise && next_bits == MFRP_ADDR_BITS;
    assign o_mem_ready = fifo_in_ready;

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetching <= 1'b0;
            pending <= 1'b0;
            live <= 1'b0;
            o_mem_rd <= 1'b0;
            o_mem_addr <= MFRP_ADDR_RESET;
        end else begin
            o_mem_rd <= 1'b0;
            if (i_mem_valid) begin
                pending <= 1'b0;
                live <= 1'b0;
            end
            if (cs_s2) begin
                fetching <= 1'b0;
                live <= 1'b0;
            end else if (addr_done) begin
                fetching <= 1'b1;
                o_mem_addr <= next_shreg;
            end else if (fetching && !pending && !o_mem_rd && fifo_in_ready) begin
                o_mem_rd <= 1'b1;
                pending <= 1'b1;
                live <= 1'b1;
            end
            if (o_mem_rd) begin
                o_mem_addr <= o_mem_addr + 24'h000001;
            end
        end
    end

    mfrp_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_flush(cs_s2),
        .i_in_valid(i_mem_valid && live),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_mem_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_data)
    );

    // ========================
    // data output on falling serial clock
    logic [7:0] obyte;
    logic [3:0] ocnt;
    logic [2:0] dw;
    logic in_data;

    assign dw = data_w(op, proto);
    assign in_data = !cs_s2 && state == ST_DATA;
    assign fifo_pop = in_data && sclk_fall && ocnt == 4'h0;

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_io <= 4'h0;
            o_io_oe_n <= MFRP_OE_N_IDLE;
            obyte <= 8'h00;
            ocnt <= 4'h0;
        end else if (!in_data) begin
            o_io_oe_n <= MFRP_OE_N_IDLE;
            ocnt <= 4'h0;
        end else if (sclk_fall) begin
            o_io_oe_n <= (dw == MFRP_W1) ? MFRP_OE_N_W1 : (dw == MFRP_W2) ? MFRP_OE_N_W2 : MFRP_OE_N_W4;
            if (ocnt == 4'h0) begin
                o_io <= top_bits(fifo_out_valid ? fifo_data : MFRP_FILL_BYTE, dw);
                obyte <= (fifo_out_valid ? fifo_data : MFRP_FILL_BYTE) << dw;
                ocnt <= MFRP_BYTE_BITS - {1'b0, dw};
            end else begin
                o_io <= top_bits(obyte, dw);
                obyte <= obyte << dw;
                ocnt <= ocnt - {1'b0, dw};
            end
        end
    end

    // ========================
    // discovery table pointer
    logic [MFRP_TBL_AW-1:0] tbl_ptr;

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tbl_ptr <= '0;
            o_tbl_data <= MFRP_TBL_BLANK;
        end else begin
            if (i_tbl_load) begin
                tbl_ptr <= i_tbl_addr;
            end else if (i_tbl_next) begin
                tbl_ptr <= tbl_ptr + 1'b1;
            end
            o_tbl_data <= tbl_byte(tbl_ptr);
        end
    end
endmodule // mfrp_read_path

`default_nettype wire

// >>> verif/mfrp_checker_sva.sv
// assertion checker for the flash read path
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// checker
module mfrp_checker (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic [3:0] o_io,
    input wire logic [3:0] o_io_oe_n,
    input wire logic [23:0] o_mem_addr,
    input wire logic o_mem_rd,
    input wire logic o_mem_ready,
    input wire logic i_tbl_load,
    input wire logic [10:0] i_tbl_addr,
    input wire logic [7:0] o_tbl_data
);
    logic sclk_d;
    logic [4:0] rises;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    // pin clock rises this frame
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sclk_d <= 1'b0;
            rises <= 5'h00;
        end else begin
            sclk_d <= i_sclk;
            if (i_cs_n)
                rises <= 5'h00;
            else if (i_sclk && !sclk_d && rises != 5'h1f)
                rises <= rises + 5'h01;
        end
    end
    cs_high_idle_a: assert property (i_cs_n [*6] |-> o_io_oe_n == 4'hf)
        else $error("driven idle");
    no_early_drive_a: assert property (!i_cs_n && rises < 5'h12 |-> o_io_oe_n == 4'hf)
        else $error("early drive");
    out_hold_a: assert property ($rose(i_sclk) |-> ##1 $stable(o_io) [*4])
        else $error("io moved");
    rd_when_room_a: assert property (o_mem_rd |-> o_mem_ready)
        else $error("rd when full");
    rd_single_a: assert property (o_mem_rd |=> !o_mem_rd)
        else $error("rd too long");
    addr_step_a: assert property (o_mem_rd |=> o_mem_addr == $past(o_mem_addr) + 24'h000001)
        else $error("no addr step");
    tbl_quad_a: assert property (i_tbl_load && i_tbl_addr == 11'h039 |-> ##2 o_tbl_data == 8'heb)
        else $error("quad op");
    tbl_erase_a: assert property (i_tbl_load && i_tbl_addr == 11'h04f |-> ##2 o_tbl_data == 8'hd8)
        else $error("erase op");
endmodule // mfrp_checker
bind mfrp_read_path mfrp_checker u_chk (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_io(o_io),
    .o_io_oe_n(o_io_oe_n), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_ready(o_mem_ready),
    .i_tbl_load(i_tbl_load), .i_tbl_addr(i_tbl_addr), .o_tbl_data(o_tbl_data)
);
`default_nettype wire

// >>> verif/mfrp_host.sv
// host controller model driving the serial link
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// host
module mfrp_host (
    input wire logic i_clk,
    input wire logic [3:0] i_io,
    input wire logic [3:0] i_oe_n,
    output var logic o_sclk,
    output var logic o_cs_n,
    output var logic [3:0] o_io
);
    logic [7:0] rx[$];
    logic early;
    logic [3:0] oe_last;
    logic [3:0] smp;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_io = 4'h0;
    end
    // one serial clock; released lines toggle
    task automatic tick(input logic [3:0] v, input bit drv);
        o_io <= drv ? v : ~o_io;
        repeat (4) @(posedge i_clk);
        smp = i_io;
        oe_last = i_oe_n;
        early |= drv && oe_last != 4'hf;
        o_sclk <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_sclk <= 1'b0;
    endtask
    // n bits msb first over w lines
    task automatic send(input logic [23:0] v, input int n, input int w);
        for (int k = 1; k <= n / w; k++)
            tick(4'((v >> (n - w * k)) & 24'((1 << w) - 1)), 1'b1);
    endtask
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int wc, input int wa,
                         input int wd, input int dm, input int nb, input int ext);
        logic [7:0] by;
        rx.delete();
        early = 1'b0;
        o_cs_n <= 1'b0;
        send({16'h0000, op}, 8, wc);
        send(a, 24, wa);
        repeat (dm) begin
            tick(4'h0, 1'b0);
            early |= oe_last != 4'hf;
        end
        repeat (nb) begin
            by = 8'h00;
            repeat (8 / wd) begin
                tick(4'h0, 1'b0);
                by = (by << wd) | 8'(wd == 1 ? {3'h0, smp[1]} : smp & 4'((1 << wd) - 1));
            end
            rx.push_back(by);
        end
        repeat (ext) tick(4'h0, 1'b0);
        @(posedge i_clk);
        o_cs_n <= 1'b1;
        repeat (8) @(posedge i_clk);
    endtask
endmodule // mfrp_host
`default_nettype wire

// >>> verif/multi_io_flash_read_path_test.sv
// self-checking bench for the flash read path
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// bench
module multi_io_flash_read_path_test import mfrp_pkg::*;;
    logic i_core_clk = 1'b0;
    logic i_rstn, i_sclk, i_cs_n, o_mem_rd, i_mem_valid, o_mem_ready, i_tbl_load, i_tbl_next;
    logic [1:0] i_proto;
    logic [3:0] i_io, o_io, o_io_oe_n;
    logic [23:0] o_mem_addr, pa;
    logic [7:0] i_mem_data, o_tbl_data;
    logic [7:0] ops [6];
    logic [10:0] i_tbl_addr;
    logic full_seen = 1'b0;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    int lc = 0;
    int lat_max = 1;
    mfrp_read_path #(.FIFO_DEPTH(4)) i_dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_sclk(i_sclk),
        .i_cs_n(i_cs_n), .i_proto(i_proto), .i_io(i_io), .o_io(o_io), .o_io_oe_n(o_io_oe_n),
        .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .i_mem_data(i_mem_data), .i_mem_valid(i_mem_valid),
        .o_mem_ready(o_mem_ready), .i_tbl_load(i_tbl_load), .i_tbl_addr(i_tbl_addr),
        .i_tbl_next(i_tbl_next), .o_tbl_data(o_tbl_data));
    mfrp_host i_host (.i_clk(i_core_clk), .i_io(o_io), .i_oe_n(o_io_oe_n), .o_sclk(i_sclk),
        .o_cs_n(i_cs_n), .o_io(i_io));
    always #10 i_core_clk = ~i_core_clk;
    function automatic logic [7:0] memb(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
    endfunction
    function automatic logic [7:0] tbl(input logic [10:0] a);
        case (a)
            11'h037: return 8'h07;
            11'h038: return 8'h29;
            11'h039, 11'h04b: return 8'heb;
            11'h03a, 11'h03e: return 8'h27;
            11'h03b: return 8'h6b;
            11'h03c: return 8'h08;
            11'h03d: return 8'h3b;
            11'h03f, 11'h047: return 8'hbb;
            11'h046: return 8'h28;
            11'h04a: return 8'h2a;
            11'h04c: return 8'h0c;
            11'h04d: return 8'h20;
            11'h04e: return 8'h10;
            11'h04f: return 8'hd8;
            11'h050, 11'h051, 11'h052, 11'h053: return 8'h00;
            default: return 8'hff;
        endcase
    endfunction
    // {accepted, cmd lines, addr lines, data lines, dummy clocks}
    function automatic logic [16:0] cfg(input logic [1:0] p, input logic [7:0] op);
        logic [3:0] w, wa, wd, d;
        logic ok;
        w = p == 2'h0 ? 4'h1 : p == 2'h1 ? 4'h2 : 4'h4;
        ok = p == 2'h0 || (p == 2'h1 && op inside {8'h0b, 8'h3b, 8'hbb}) || (p == 2'h2 && op inside {8'h0b, 8'h6b, 8'heb});
        wa = w;
        wd = w;
        case (op)
            8'h03: d = 4'h0;
            8'h0b: d = p == 2'h2 ? 4'ha : 4'h8;
            8'hbb: d = p == 2'h1 ? 4'h9 : 4'h8;
            8'heb: d = p == 2'h2 ? 4'hb : 4'ha;
            default: d = 4'h8;
        endcase
        if (p == 2'h0) begin
            wa = op == 8'hbb ? 4'h2 : op == 8'heb ? 4'h4 : 4'h1;
            wd = op inside {8'h03, 8'h0b} ? 4'h1 : op inside {8'h3b, 8'hbb} ? 4'h2 : 4'h4;
        end
        return {ok, w, wa, wd, d};
    endfunction
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic tbl_step(input bit ld, input logic [10:0] a);
        i_tbl_load <= ld;
        i_tbl_addr <= a;
        i_tbl_next <= !ld;
        @(posedge i_core_clk);
        i_tbl_load <= 1'b0;
        i_tbl_next <= 1'b0;
        repeat (3) @(posedge i_core_clk);
    endtask
    // array model, answers 1 to lat_max cycles after a read
    always @(posedge i_core_clk) begin
        full_seen <= full_seen | !o_mem_ready;
        if (o_mem_rd) begin
            pa = o_mem_addr;
            lc = $urandom_range(lat_max, 1);
        end else if (lc > 0) begin
            lc = lc - 1;
        end
        i_mem_valid <= lc == 1;
        i_mem_data <= memb(pa);
    end
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        logic [16:0] c;
        logic [7:0] op;
        logic [23:0] a;
        void'($urandom(32'h68c62498));
        {i_rstn, i_proto, i_tbl_load, i_tbl_next, i_tbl_addr, i_mem_valid, i_mem_data} = '0;
        ops = '{MFRP_OP_READ, MFRP_OP_FAST, MFRP_OP_DOUT, MFRP_OP_DIO, MFRP_OP_QOUT, MFRP_OP_QIO};
        repeat (4) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        for (int i = 0; i < 16; i++) begin
            i_proto <= i < 6 ? 2'h0 : 2'($urandom_range(3, 0));
            op = ops[i < 6 ? i : $urandom_range(5, 0)];
            a = i == 0 ? 24'hfffffe : 24'($urandom);
            @(posedge i_core_clk);
            c = cfg(i_proto, op);
            lat_max = op == 8'h03 ? 1 : 5;
            i_host.frame(op, a, c[15:12], c[11:8], c[7:4], c[3:0],
                         $urandom_range(5, 2), $urandom_range(3, 0));
            check("early", i_host.early, 1'b0);
            check("enable", i_host.oe_last, c[16] ? (c[7:4] == 4'h1 ? 4'hd : c[7:4] == 4'h2 ? 4'hc : 4'h0) : 4'hf);
            if (c[16])
                foreach (i_host.rx[k])
                    check("data", i_host.rx[k], memb(a + 24'(k)));
            check("released", o_io_oe_n, 4'hf);
        end
        check("fifo full", full_seen, 1'b1);
        for (int t = 'h30; t < 'h56; t++) begin
            tbl_step(1'b1, 11'(t));
            check("table", o_tbl_data, tbl(11'(t)));
        end
        tbl_step(1'b1, 11'h7ff);
        repeat (8'h38) tbl_step(1'b0, 11'h000);
        check("wrap", o_tbl_data, 8'h07);
        print_verdict();
    end
endmodule // multi_io_flash_read_path_test
`default_nettype wire
